// File: rtl/cycle_seq.sv
// Machine-cycle sequencer, I/O request service and Wishbone register slave
// Function
// - Data moves over one shared 8-bit two-way bus among processor, memory, I/O.
// - I/O command lines stay low except while an I/O instruction executes.
// - During I/O execution command lines copy the low instruction nibble bits.
// - Transfer direction comes from the nibble direction bit, shown on read level.
// - Read level high means I/O to memory, low means memory to I/O.
// - The four external flags are sampled at the start of each execute cycle.
// - Branch logic can test each sampled flag separately.
// - Requests are sampled between the late pulse and the next early pulse.
// - Taking an interrupt copies data and program selectors into the shadow pair.
// - Interrupt acknowledge sets data selector to 2, program selector to 1.
// - Interrupt acknowledge clears the interrupt enable flag.
// - Interrupt acknowledge takes exactly one machine cycle.
// - DMA waits for instruction end, moves a byte at scratch 0, increments it.
// - Priority is inbound DMA, then outbound DMA, then interrupt.
// - State code: fetch 00, execute 01, DMA 10, interrupt 11.
// - State code is valid by the early timing pulse of each cycle.
// - Instructions take fetch plus one execute; long branch and skip take two.
// - Each machine cycle lasts eight clock pulses.
// - Every cycle has one early then one late timing pulse.
// - Address high byte goes out first, low byte after the early pulse.
// - Clear and wait decode to load, reset, pause and run.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cycle_seq
	import cycle_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic wait_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] core_data_i,
	input wire logic core_write_i,
	input wire logic [15:0] core_addr_i,
	input wire logic [3:0] external_flag_inputs_i,
	input wire logic dma_in_req_i,
	input wire logic dma_out_req_i,
	input wire logic intr_req_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic [7:0] multiplexed_address_lines_o,
	output logic [1:0] cycle_state_code_o,
	output logic [2:0] io_command_lines_o,
	output logic read_level_o,
	output logic early_timing_pulse_o,
	output logic late_timing_pulse_o,
	output logic [3:0] flag_test_o,
	output logic [3:0] instr_high_o,
	output logic [3:0] instr_low_o,
	output logic [3:0] pc_sel_o,
	output logic [3:0] data_sel_o
);
	mode_t mode;
	cyc_state_t state_ff, nxt_state;
	logic [2:0] slot;
	logic cycle_end, run, seq_rst;
	logic [3:0] ihi_ff, nxt_ihi, ilo_ff, nxt_ilo;
	logic [3:0] pc_ff, nxt_pc, dp_ff, nxt_dp;
	logic [7:0] shadow_ff, nxt_shadow;
	logic ie_ff, nxt_ie;
	logic [15:0] r0_ff, nxt_r0;
	logic [7:0] addr_ff, nxt_addr;
	logic [1:0] sc_ff, nxt_sc;
	logic [2:0] ioc_ff, nxt_ioc;
	logic rl_ff, nxt_rl;
	logic [7:0] dout_ff, nxt_dout;
	logic oe_ff, nxt_oe;
	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic long_ff, nxt_long;
	req_t req_raw, req_held;
	logic take_req, take_flags;
	logic is_io, wb_req, wb_wr;
	logic [15:0] cur_addr;

	// Clear and wait decode
	always_comb begin
		case ({clear_i, wait_i})
			2'b00: mode = MODE_LOAD;
			2'b01: mode = MODE_RESET;
			2'b10: mode = MODE_PAUSE;
			default: mode = MODE_RUN;
		endcase
	end

	assign seq_rst = rst_i || (mode == MODE_RESET);
	assign run = (mode == MODE_RUN);

	cycle_timer u_timer (
		.clk_i(clk_i),
		.rst_i(seq_rst),
		.run_i(run),
		.early_en_i(mode != MODE_LOAD),
		.slot_o(slot),
		.early_timing_pulse_o(early_timing_pulse_o),
		.late_timing_pulse_o(late_timing_pulse_o),
		.cycle_end_o(cycle_end)
	);

	// Requests are captured on the late pulse and held into the next early pulse
	assign req_raw = '{dma_in: dma_in_req_i, dma_out: dma_out_req_i, intr: intr_req_i};
	assign take_req = late_timing_pulse_o;

	sample_hold #(
		.WIDTH(3)
	) u_req (
		.clk_i(clk_i),
		.rst_i(seq_rst),
		.take_i(take_req),
		.d_i(req_raw),
		.q_o(req_held)
	);

	// Flags taken on the first slot of every execute cycle
	assign take_flags = run && (slot == 3'h0) && ((state_ff == ST_EXEC) || (state_ff == ST_EXEC2));

	sample_hold #(
		.WIDTH(4)
	) u_flags (
		.clk_i(clk_i),
		.rst_i(seq_rst),
		.take_i(take_flags),
		.d_i(external_flag_inputs_i),
		.q_o(flag_test_o)
	);

	assign is_io = (ihi_ff == OP_IO) && (ilo_ff[2:0] != 3'h0);
	assign cur_addr = (state_ff == ST_DMA) ? r0_ff : core_addr_i;
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wb_wr = wb_req && wb_we_i;

	// Machine-cycle sequencing and interrupt/DMA actions
	always_comb begin
		nxt_state = state_ff;
		nxt_ihi = ihi_ff;
		nxt_ilo = ilo_ff;
		nxt_pc = pc_ff;
		nxt_dp = dp_ff;
		nxt_shadow = shadow_ff;
		nxt_ie = ie_ff;
		nxt_r0 = r0_ff;
		nxt_long = long_ff;
		if (run && (slot == LATE_SLOT) && (state_ff == ST_FETCH)) begin
			nxt_ihi = data_i[7:4];
			nxt_ilo = data_i[3:0];
			nxt_long = (data_i[7:4] == OP_LONG);
		end
		if (cycle_end) begin
			case (state_ff)
				ST_FETCH: nxt_state = ST_EXEC;
				ST_EXEC, ST_EXEC2, ST_DMA, ST_INT: begin
					if ((state_ff == ST_EXEC) && long_ff) begin
						nxt_state = ST_EXEC2;
					end else if (state_ff == ST_INT) begin
						nxt_state = ST_FETCH;
					end else if (req_held.dma_in || req_held.dma_out) begin
						nxt_state = ST_DMA;
					end else if (req_held.intr && ie_ff) begin
						nxt_state = ST_INT;
						nxt_shadow = {dp_ff, pc_ff};
					end else begin
						nxt_state = ST_FETCH;
					end
					if (state_ff == ST_DMA) begin
						nxt_r0 = r0_ff + 16'h0001;
					end
				end
				default: nxt_state = ST_FETCH;
			endcase
		end
		if (run && (slot == 3'h0) && (state_ff == ST_INT)) begin
			nxt_dp = INT_DATA_SEL;
			nxt_pc = INT_PC_SEL;
			nxt_ie = 1'b0;
		end else if (wb_wr && (wb_adr_i[3:0] == CTRL_ADDR) && wb_sel_i[0]) begin
			nxt_ie = wb_dat_i[CTRL_IE_BIT];
			nxt_pc = wb_dat_i[CTRL_PC_LSB +: 4];
			nxt_dp = wb_sel_i[1] ? wb_dat_i[CTRL_DP_LSB +: 4] : dp_ff;
		end
		if (wb_wr && (wb_adr_i[3:0] == R0_ADDR) && !(cycle_end && (state_ff == ST_DMA))) begin
			nxt_r0[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : r0_ff[7:0];
			nxt_r0[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : r0_ff[15:8];
		end
	end

	// Pin outputs: state code, address, I/O command, read level, data
	always_comb begin
		nxt_sc = sc_ff;
		nxt_addr = addr_ff;
		nxt_ioc = 3'h0;
		nxt_rl = 1'b1;
		nxt_dout = dout_ff;
		nxt_oe = 1'b0;
		case (nxt_state)
			ST_FETCH: nxt_sc = SC_FETCH;
			ST_EXEC, ST_EXEC2: nxt_sc = SC_EXEC;
			ST_DMA: nxt_sc = SC_DMA;
			ST_INT: nxt_sc = SC_INT;
			default: nxt_sc = SC_FETCH;
		endcase
		if (slot < EARLY_SLOT + 3'h1) begin
			nxt_addr = cur_addr[15:8];
		end else begin
			nxt_addr = cur_addr[7:0];
		end
		// Decode the coming state so pins switch at the cycle boundary together with the state code
		case (nxt_state)
			ST_FETCH: nxt_rl = 1'b0;
			ST_DMA: nxt_rl = cycle_end ? req_held.dma_in : rl_ff;
			ST_EXEC: begin
				if (is_io) begin
					nxt_ioc = ilo_ff[2:0];
					nxt_rl = ilo_ff[3];
				end else begin
					nxt_rl = core_write_i;
					nxt_oe = core_write_i;
					nxt_dout = core_data_i;
				end
			end
			default: nxt_rl = 1'b1;
		endcase
		if (!run) begin
			nxt_ioc = ioc_ff;
			nxt_rl = rl_ff;
			nxt_oe = oe_ff;
		end
	end

	// Wishbone slave: one wait state, ack for every address, zero from unmapped
	always_comb begin
		nxt_ack = wb_req;
		nxt_rdat = 32'h0;
		case (wb_adr_i[3:0])
			CTRL_ADDR: begin
				nxt_rdat[CTRL_IE_BIT] = ie_ff;
				nxt_rdat[CTRL_PC_LSB +: 4] = pc_ff;
				nxt_rdat[CTRL_DP_LSB +: 4] = dp_ff;
			end
			STATUS_ADDR: begin
				nxt_rdat[STAT_SC_LSB +: 2] = sc_ff;
				nxt_rdat[STAT_FLAG_LSB +: 4] = flag_test_o;
				nxt_rdat[STAT_SHADOW_LSB +: 8] = shadow_ff;
				nxt_rdat[STAT_IE_BIT] = ie_ff;
				nxt_rdat[STAT_MODE_LSB +: 4] = mode;
			end
			R0_ADDR: nxt_rdat[15:0] = r0_ff;
			default: nxt_rdat = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (seq_rst) begin
			state_ff <= ST_FETCH;
			ihi_ff <= 4'h0;
			ilo_ff <= 4'h0;
			pc_ff <= RST_SEL;
			dp_ff <= RST_SEL;
			shadow_ff <= 8'h00;
			ie_ff <= RST_IE;
			r0_ff <= RST_R0;
			long_ff <= 1'b0;
			addr_ff <= 8'h00;
			sc_ff <= SC_FETCH;
			ioc_ff <= 3'h0;
			rl_ff <= 1'b1;
			dout_ff <= 8'h00;
			oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ihi_ff <= nxt_ihi;
			ilo_ff <= nxt_ilo;
			pc_ff <= nxt_pc;
			dp_ff <= nxt_dp;
			shadow_ff <= nxt_shadow;
			ie_ff <= nxt_ie;
			r0_ff <= nxt_r0;
			long_ff <= nxt_long;
			addr_ff <= nxt_addr;
			sc_ff <= nxt_sc;
			ioc_ff <= nxt_ioc;
			rl_ff <= nxt_rl;
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end else begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign data_o = dout_ff;
	assign data_oe_o = oe_ff;
	assign multiplexed_address_lines_o = addr_ff;
	assign cycle_state_code_o = sc_ff;
	assign io_command_lines_o = ioc_ff;
	assign read_level_o = rl_ff;
	assign instr_high_o = ihi_ff;
	assign instr_low_o = ilo_ff;
	assign pc_sel_o = pc_ff;
	assign data_sel_o = dp_ff;
endmodule
`default_nettype wire

// File: rtl/cycle_pkg.sv
// Shared constants, types and register map of the machine-cycle sequencer
package cycle_pkg;
	localparam int CYCLE_CLKS = 8;
	localparam logic [2:0] EARLY_SLOT = 3'h1;
	localparam logic [2:0] LATE_SLOT = 3'h6;
	localparam logic [2:0] LAST_SLOT = 3'(CYCLE_CLKS - 1);
	localparam logic [3:0] OP_IO = 4'h6;
	localparam logic [3:0] OP_LONG = 4'hc;
	localparam logic [3:0] INT_DATA_SEL = 4'h2;
	localparam logic [3:0] INT_PC_SEL = 4'h1;
	localparam logic [3:0] RST_SEL = 4'h0;
	localparam logic RST_IE = 1'b1;
	localparam logic [15:0] RST_R0 = 16'h0000;
	// Register byte offsets
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] R0_ADDR = 4'h8;
	// Control register fields
	localparam int CTRL_IE_BIT = 0;
	localparam int CTRL_PC_LSB = 4;
	localparam int CTRL_DP_LSB = 8;
	// Status register fields
	localparam int STAT_SC_LSB = 0;
	localparam int STAT_FLAG_LSB = 4;
	localparam int STAT_SHADOW_LSB = 8;
	localparam int STAT_IE_BIT = 16;
	localparam int STAT_MODE_LSB = 20;
	localparam logic [1:0] SC_FETCH = 2'b00;
	localparam logic [1:0] SC_EXEC = 2'b01;
	localparam logic [1:0] SC_DMA = 2'b10;
	localparam logic [1:0] SC_INT = 2'b11;

	typedef enum logic [3:0] {
		MODE_LOAD = 4'b0001,
		MODE_RESET = 4'b0010,
		MODE_PAUSE = 4'b0100,
		MODE_RUN = 4'b1000
	} mode_t;

	typedef enum logic [4:0] {
		ST_FETCH = 5'b00001,
		ST_EXEC = 5'b00010,
		ST_EXEC2 = 5'b00100,
		ST_DMA = 5'b01000,
		ST_INT = 5'b10000
	} cyc_state_t;

	typedef struct packed {
		logic dma_in;
		logic dma_out;
		logic intr;
	} req_t;
endpackage

// File: rtl/cycle_timer.sv
// Eight-slot machine-cycle divider with early and late timing pulses
`timescale 1ns/10ps
`default_nettype none
module cycle_timer
	import cycle_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic early_en_i,
	output logic [2:0] slot_o,
	output logic early_timing_pulse_o,
	output logic late_timing_pulse_o,
	output logic cycle_end_o
);
	logic [2:0] slot_ff, nxt_slot;
	logic early_ff, nxt_early;
	logic late_ff, nxt_late;

	always_comb begin
		nxt_slot = slot_ff;
		nxt_early = 1'b0;
		nxt_late = 1'b0;
		if (run_i) begin
			nxt_slot = slot_ff + 3'h1;
			nxt_early = (nxt_slot == EARLY_SLOT) && early_en_i;
			nxt_late = (nxt_slot == LATE_SLOT);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_ff <= 3'h0;
			early_ff <= 1'b0;
			late_ff <= 1'b0;
		end else begin
			slot_ff <= nxt_slot;
			early_ff <= nxt_early;
			late_ff <= nxt_late;
		end
	end

	assign slot_o = slot_ff;
	assign early_timing_pulse_o = early_ff;
	assign late_timing_pulse_o = late_ff;
	assign cycle_end_o = run_i && (slot_ff == LAST_SLOT);
endmodule
`default_nettype wire

// File: rtl/sample_hold.sv
// Generic sampling register that captures its input on a strobe
`timescale 1ns/10ps
`default_nettype none
module sample_hold #(
	parameter int WIDTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic take_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] q_ff, nxt_q;

	always_comb begin
		nxt_q = take_i ? d_i : q_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign q_o = q_ff;
endmodule
`default_nettype wire

// File: verification/cycle_seq_monitor.sv
// Port assertions for the machine-cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module cycle_seq_monitor
	import cycle_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic wait_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] cycle_state_code_o,
	input wire logic [2:0] io_command_lines_o,
	input wire logic read_level_o,
	input wire logic early_timing_pulse_o,
	input wire logic late_timing_pulse_o,
	input wire logic [3:0] instr_high_o,
	input wire logic [3:0] instr_low_o,
	input wire logic [3:0] data_sel_o,
	input wire logic [3:0] pc_sel_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || !(clear_i && wait_i));
	logic io_x;
	assign io_x = cycle_state_code_o == SC_EXEC && instr_high_o == OP_IO;
	sequence int_start;
		$rose(cycle_state_code_o == SC_INT);
	endsequence
	sequence int_body;
		(cycle_state_code_o == SC_INT) [*7] ##1 cycle_state_code_o == SC_FETCH;
	endsequence
	io_idle_a: assert property (cycle_state_code_o != SC_EXEC |-> io_command_lines_o == 3'h0)
		else $error("io lines active outside execute");
	io_copy_a: assert property (io_x |-> io_command_lines_o == instr_low_o[2:0])
		else $error("io lines differ from instruction nibble");
	io_dir_a: assert property (io_x && instr_low_o[2:0] != 3'h0 |-> read_level_o == instr_low_o[3])
		else $error("read level differs from direction bit");
	pulse_order_a: assert property (early_timing_pulse_o |-> ##5 late_timing_pulse_o)
		else $error("late pulse not five clocks after early pulse");
	cycle_len_a: assert property (early_timing_pulse_o |-> ##8 early_timing_pulse_o)
		else $error("machine cycle not eight clocks");
	code_hold_a: assert property ($changed(cycle_state_code_o) |=> $stable(cycle_state_code_o) [*7])
		else $error("state code changed inside a cycle");
	int_sel_a: assert property (cycle_state_code_o == SC_INT && late_timing_pulse_o |-> data_sel_o == 4'h2 && pc_sel_o == 4'h1)
		else $error("selectors wrong in interrupt cycle");
	int_once_a: assert property (int_start |=> int_body)
		else $error("interrupt cycle length or successor wrong");
	fetch_next_a: assert property ($past(cycle_state_code_o) == SC_FETCH && cycle_state_code_o != SC_FETCH |-> cycle_state_code_o == SC_EXEC)
		else $error("fetch not followed by execute");
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus acknowledge late or too long");
endmodule
`default_nettype wire

// File: verification/bus_partner.sv
// Memory and I/O side model driving the shared data bus
`timescale 1ns/10ps
`default_nettype none
module bus_partner
	import cycle_pkg::*;
(
	input wire logic clk_i,
	input wire logic [1:0] cycle_state_code_i,
	input wire logic [7:0] prog_i,
	input wire logic [7:0] dev_data_i,
	input wire logic dev_oe_i,
	output logic [7:0] bus_o
);
	logic [7:0] junk_ff = 8'h5a;
	always @(posedge clk_i) begin
		junk_ff <= ~junk_ff;
	end
	// Memory answers fetches; a released bus never keeps stale data
	assign bus_o = dev_oe_i ? dev_data_i : (cycle_state_code_i == SC_FETCH ? prog_i : junk_ff);
endmodule
`default_nettype wire

// File: verification/test_cycle_seq.sv
// Self-checking bench for the machine-cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module test_cycle_seq;
	import cycle_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clear_i = 1'b1;
	logic wait_i = 1'b1;
	logic [3:0] external_flag_inputs_i = 4'ha;
	logic dma_in_req_i = 1'b0;
	logic dma_out_req_i = 1'b0;
	logic intr_req_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [7:0] prog = 8'h6b;
	logic core_write = 1'b0;
	logic [15:0] core_addr = 16'h1234;
	logic [7:0] data_i, data_o, multiplexed_address_lines_o;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, data_oe_o, read_level_o, early_timing_pulse_o, late_timing_pulse_o, hit;
	logic [1:0] cycle_state_code_o;
	logic [2:0] io_command_lines_o;
	logic [3:0] flag_test_o, instr_high_o, instr_low_o, pc_sel_o, data_sel_o;
	int error_cnt = 0;
	int comparisons = 0;
	cycle_seq dut (.clk_i, .rst_i, .clear_i, .wait_i, .data_i, .core_data_i(8'h5a), .core_write_i(core_write),
		.core_addr_i(core_addr), .external_flag_inputs_i, .dma_in_req_i, .dma_out_req_i, .intr_req_i,
		.wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .data_o,
		.data_oe_o, .multiplexed_address_lines_o, .cycle_state_code_o, .io_command_lines_o, .read_level_o,
		.early_timing_pulse_o, .late_timing_pulse_o, .flag_test_o, .instr_high_o, .instr_low_o, .pc_sel_o,
		.data_sel_o);
	bus_partner mem (.clk_i, .cycle_state_code_i(cycle_state_code_o), .prog_i(prog), .dev_data_i(data_o),
		.dev_oe_i(data_oe_o), .bus_o(data_i));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			give_verdict();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	// Waits for an early pulse, of any cycle or of the given state
	task automatic ep(input logic [1:0] code, input bit any);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(early_timing_pulse_o === 1'b1 && (any || cycle_state_code_o === code)) && n < 400);
		if (n >= 400) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 32'(CTRL_ADDR), 32'h0, 4'hf);
		check("ctrl reset", rd, 32'h1);
		wb(1'b0, 32'hc, 32'h0, 4'hf);
		check("unmapped", rd, 32'h0);
		wb(1'b1, 32'(CTRL_ADDR), 32'h531, 4'h3);
		wb(1'b1, 32'(R0_ADDR), 32'h10, 4'h3);
		wb(1'b0, 32'(R0_ADDR), 32'h0, 4'hf);
		check("r0", rd & 32'hffff, 32'h10);
		ep(SC_FETCH, 0);
		check("addr high", multiplexed_address_lines_o, 32'h12);
		repeat (2) @(posedge clk_i);
		check("addr low", multiplexed_address_lines_o, 32'h34);
		ep(SC_EXEC, 0);
		check("io", io_command_lines_o, 32'h3);
		check("dir in", read_level_o, 32'h1);
		check("flags", flag_test_o, 32'ha);
		prog <= 8'h63;
		external_flag_inputs_i <= 4'h5;
		ep(SC_FETCH, 0);
		ep(SC_EXEC, 0);
		check("io", io_command_lines_o, 32'h3);
		check("dir out", read_level_o, 32'h0);
		check("flags", flag_test_o, 32'h5);
		prog <= 8'hc4;
		ep(SC_FETCH, 0);
		ep(SC_EXEC, 0);
		check("io idle", io_command_lines_o, 32'h0);
		ep(2'b00, 1);
		check("exec2", cycle_state_code_o, 32'(SC_EXEC));
		prog <= 8'h10;
		ep(2'b00, 1);
		check("next fetch", cycle_state_code_o, 32'(SC_FETCH));
		core_write <= 1'b1;
		ep(SC_EXEC, 0);
		check("write", {data_oe_o, read_level_o, data_o}, {1'b1, 1'b1, 8'h5a});
		core_write <= 1'b0;
		dma_in_req_i <= 1'b1;
		dma_out_req_i <= 1'b1;
		intr_req_i <= 1'b1;
		ep(SC_DMA, 0);
		check("dma in", read_level_o, 32'h1);
		repeat (2) @(posedge clk_i);
		check("dma addr", multiplexed_address_lines_o, 32'h10);
		dma_in_req_i <= 1'b0;
		ep(2'b00, 1);
		check("dma out", {cycle_state_code_o, read_level_o}, {SC_DMA, 1'b0});
		dma_out_req_i <= 1'b0;
		ep(2'b00, 1);
		check("int", cycle_state_code_o, 32'(SC_INT));
		ep(2'b00, 1);
		check("after int", cycle_state_code_o, 32'(SC_FETCH));
		wb(1'b0, 32'(STATUS_ADDR), 32'h0, 4'hf);
		check("status", rd & 32'h00f1ff00, 32'h00805300);
		wb(1'b0, 32'(CTRL_ADDR), 32'h0, 4'hf);
		check("ctrl", rd, 32'h210);
		wb(1'b0, 32'(R0_ADDR), 32'h0, 4'hf);
		check("r0 step", rd & 32'hffff, 32'h12);
		hit = 1'b0;
		repeat (12) begin
			ep(2'b00, 1);
			hit = hit | (cycle_state_code_o === SC_INT);
		end
		check("masked", hit, 32'h0);
		wb(1'b1, 32'(CTRL_ADDR), 32'h211, 4'h3);
		repeat (6) begin
			ep(2'b00, 1);
			hit = hit | (cycle_state_code_o === SC_INT);
		end
		check("enabled", hit, 32'h1);
		intr_req_i <= 1'b0;
		wait_i <= 1'b0;
		wb(1'b0, 32'(STATUS_ADDR), 32'h0, 4'hf);
		check("pause", rd[23:20], 32'(MODE_PAUSE));
		clear_i <= 1'b0;
		wait_i <= 1'b1;
		wb(1'b0, 32'(STATUS_ADDR), 32'h0, 4'hf);
		check("reset mode", rd & 32'h00f10003, 32'h00210000);
		wait_i <= 1'b0;
		hit = 1'b0;
		repeat (20) begin
			@(posedge clk_i);
			hit = hit | (early_timing_pulse_o === 1'b1);
		end
		check("load", hit, 32'h0);
		clear_i <= 1'b1;
		wait_i <= 1'b1;
		ep(2'b00, 1);
		check("restart", cycle_state_code_o, 32'(SC_FETCH));
		give_verdict();
	end
endmodule
bind cycle_seq cycle_seq_monitor mon (.clk_i, .rst_i, .clear_i, .wait_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.cycle_state_code_o, .io_command_lines_o, .read_level_o, .early_timing_pulse_o, .late_timing_pulse_o,
	.instr_high_o, .instr_low_o, .data_sel_o, .pc_sel_o);
`default_nettype wire
